// File: design/host_link_regs.sv
// Purpose: timestamp trigger, host link control and host link status
// Assumes: host interface core hands over single-cycle byte transactions
// Notes:   read data appears one cycle after the read strobe

`timescale 1ns/10ps
`default_nettype none

module host_link_regs #(
  parameter int unsigned MS_CYCLES = host_regs_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_in,
  // host register transactions
  input  wire host_regs_pkg::host_req_t req_in,
  output logic [7:0]                    rd_data_out,
  // channel data and firmware state
  input  wire logic [7:0]               chan_data_in,
  input  wire logic [3:0]               not_ready_in,
  input  wire logic                     sleeping_in,
  input  wire logic                     deep_sleep_in,
  input  wire logic                     timer_osc_en_in,
  // start-up protocol strap pin, 1 = serial peripheral
  input  wire logic                     proto_pin_in,
  // timestamp source and destination select
  input  wire logic                     ts_to_reg_in,
  input  wire logic [39:0]              timer_in,
  output logic [39:0]                   ts_reg_out,
  // status channel packet stream
  output logic                          pkt_valid_out,
  output logic [7:0]                    pkt_byte_out,
  output logic                          pkt_last_out,
  input  wire logic                     pkt_ready_in,
  // link side controls
  input  wire logic                     i2c_activity_in,
  output logic                          spi_3wire_out,
  output logic                          wd_timeout_out
);

  logic                      proto_s1_q;
  logic                      proto_s2_q;
  logic                      proto_q;
  logic                      strap_done_q;
  logic [7:0]                ctrl_q;
  logic [39:0]               pkt_ts_q;
  logic [3:0]                idx_q;
  host_regs_pkg::pkt_state_t state_q;

  wire logic [7:0] addr = req_in.addr;

  // packet byte at a given offset, stamp sent low byte first
  function automatic logic [7:0] pkt_byte(input logic [3:0]  idx,
                                          input logic [39:0] ts);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'h0: b = host_regs_pkg::PKT_CODE[7:0];
      4'h1: b = host_regs_pkg::PKT_CODE[15:8];
      4'h2: b = host_regs_pkg::PKT_LEN[7:0];
      4'h3: b = host_regs_pkg::PKT_LEN[15:8];
      4'h4: b = ts[7:0];
      4'h5: b = ts[15:8];
      4'h6: b = ts[23:16];
      4'h7: b = ts[31:24];
      4'h8: b = ts[39:32];
      default: b = 8'h00;                       // reserved tail
    endcase
    return b;
  endfunction

  // write decode; the trigger only acts when its bit is one
  wire logic ts_wr    = req_in.wr && (addr == host_regs_pkg::TS_TRIG_ADDR);
  wire logic ts_fire  = ts_wr && req_in.wdata[host_regs_pkg::TS_TRIG_BIT];
  wire logic ts_store = ts_fire && ts_to_reg_in;
  wire logic ts_pkt   = ts_fire && !ts_to_reg_in;
  // a burst never reaches the control bits
  wire logic ctrl_wr  = req_in.wr && !req_in.burst &&
                        (addr == host_regs_pkg::CTRL_ADDR);

  // packet handshake
  wire logic pkt_idle = (state_q == host_regs_pkg::PKT_IDLE);
  wire logic pkt_take = pkt_valid_out && pkt_ready_in;
  wire logic pkt_go   = ts_pkt && pkt_idle;
  wire logic [3:0] idx_nx = idx_q + 4'h1;

  // read selection; the status byte is assembled live
  wire logic in_chan = (addr <= host_regs_pkg::CHAN_LAST_ADDR);
  wire logic in_hits = (addr >= host_regs_pkg::HITS_FIRST) &&
                       (addr <= host_regs_pkg::HITS_LAST);
  wire logic [2:0] hits_i = 3'(addr - host_regs_pkg::HITS_FIRST);
  wire logic [7:0] stat_byte = {not_ready_in,
                                2'b00,
                                proto_q,
                                sleeping_in};
  wire logic [7:0] chan_byte = not_ready_in[addr[1:0]] ? 8'h00
                                                       : chan_data_in;
  wire logic [7:0] hits_byte = ts_reg_out[8*hits_i +: 8];
  wire logic [7:0] rd_sel =
    in_chan                          ? chan_byte :
    (addr == host_regs_pkg::CTRL_ADDR) ? ctrl_q :
    (addr == host_regs_pkg::STAT_ADDR) ? stat_byte :
    in_hits                          ? hits_byte : 8'h00;
  // trigger register and unmapped addresses read zero

  // watchdog runs only in two-wire mode with oscillator up, not in deep sleep
  wire logic wd_run = ctrl_q[host_regs_pkg::CTRL_WD_BIT] && !proto_q &&
                      timer_osc_en_in && !deep_sleep_in;

  // strap synchroniser; second stage alone is read
  always_ff @(posedge mclk_in) begin
    proto_s1_q <= proto_pin_in;
    proto_s2_q <= proto_s1_q;
  end

  // protocol caught once, at the first edge after reset release
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      proto_q      <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      proto_q      <= proto_s2_q;
      strap_done_q <= 1'b1;
    end
  end

  // control register, reserved bits stay zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl_q <= host_regs_pkg::CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= req_in.wdata & host_regs_pkg::CTRL_MASK;
    end
  end
  // status address has no write path at all

  // 3-wire select only matters in serial peripheral mode
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      spi_3wire_out <= 1'b0;
    end else begin
      spi_3wire_out <= ctrl_q[host_regs_pkg::CTRL_3W_BIT] && proto_q;
    end
  end

  // read data register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (req_in.rd) begin
      rd_data_out <= rd_sel;
    end
  end

  // stamp taken in the same cycle as the write strobe
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ts_reg_out <= host_regs_pkg::TS_RST;
    end else if (ts_store) begin
      ts_reg_out <= timer_in;
    end
  end

  // packet sender; a trigger while a packet is in flight is dropped,
  // since the status channel cannot hold two stamps here
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_q       <= host_regs_pkg::PKT_IDLE;
      idx_q         <= 4'h0;
      pkt_ts_q      <= host_regs_pkg::TS_RST;
      pkt_valid_out <= 1'b0;
      pkt_byte_out  <= 8'h00;
      pkt_last_out  <= 1'b0;
    end else begin
      unique case (state_q)
        host_regs_pkg::PKT_IDLE: begin
          if (pkt_go) begin
            state_q       <= host_regs_pkg::PKT_SEND;
            idx_q         <= 4'h0;
            pkt_ts_q      <= timer_in;
            pkt_valid_out <= 1'b1;
            pkt_byte_out  <= pkt_byte(4'h0, timer_in);
            pkt_last_out  <= 1'b0;
          end
        end
        host_regs_pkg::PKT_SEND: begin
          if (pkt_take) begin
            if (pkt_last_out) begin
              state_q       <= host_regs_pkg::PKT_IDLE;
              pkt_valid_out <= 1'b0;
              pkt_last_out  <= 1'b0;
              pkt_byte_out  <= 8'h00;
            end else begin
              idx_q        <= idx_nx;
              pkt_byte_out <= pkt_byte(idx_nx, pkt_ts_q);
              pkt_last_out <= (idx_nx == host_regs_pkg::PKT_LAST);
            end
          end
        end
      endcase
    end
  end

  // inactivity watchdog on the millisecond enable
  i2c_watchdog #(
    .MS_CYCLES   (MS_CYCLES)
  ) u_wd (
    .mclk_in     (mclk_in),
    .rst_in      (rst_in),
    .run_in      (wd_run),
    .long_in     (ctrl_q[host_regs_pkg::CTRL_TO_BIT]),
    .activity_in (i2c_activity_in),
    .timeout_out (wd_timeout_out)
  );

  // checks

  sequence s_pkt_start;
    ts_pkt && pkt_idle;
  endsequence

  sequence s_stat_rd;
    req_in.rd && (addr == host_regs_pkg::STAT_ADDR);
  endsequence

  property p_ts_reg;
    @(posedge mclk_in) disable iff (rst_in)
    ts_store |=> ts_reg_out == $past(timer_in);
  endproperty
  a_ts_reg: assert property (p_ts_reg)
    else $error("stamp not stored in timestamp bytes");

  property p_no_trig;
    @(posedge mclk_in) disable iff (rst_in)
    !ts_fire && pkt_idle |=> $stable(ts_reg_out) && !pkt_valid_out;
  endproperty
  a_no_trig: assert property (p_no_trig)
    else $error("stamp produced without trigger bit");

  property p_pkt_head;
    @(posedge mclk_in) disable iff (rst_in)
    s_pkt_start |=> pkt_valid_out && pkt_byte_out == 8'h00
                    && pkt_ts_q == $past(timer_in);
  endproperty
  a_pkt_head: assert property (p_pkt_head)
    else $error("status packet not started");

  property p_pkt_code;
    @(posedge mclk_in) disable iff (rst_in)
    s_pkt_start ##1 pkt_ready_in |=> pkt_byte_out == 8'h00;
  endproperty
  a_pkt_code: assert property (p_pkt_code)
    else $error("status code high byte not zero");

  property p_pkt_len;
    @(posedge mclk_in) disable iff (rst_in)
    s_pkt_start ##1 pkt_ready_in [*2] |=> pkt_byte_out == 8'h08;
  endproperty
  a_pkt_len: assert property (p_pkt_len)
    else $error("length low byte not eight");

  property p_pkt_end;
    @(posedge mclk_in) disable iff (rst_in)
    pkt_take && pkt_last_out |=> !pkt_valid_out && idx_q == 4'hb;
  endproperty
  a_pkt_end: assert property (p_pkt_end)
    else $error("packet not closed after twelve bytes");

  property p_3wire;
    @(posedge mclk_in) disable iff (rst_in)
    !proto_q |=> !spi_3wire_out;
  endproperty
  a_3wire: assert property (p_3wire)
    else $error("3-wire select active outside serial mode");

  property p_burst;
    @(posedge mclk_in) disable iff (rst_in)
    req_in.wr && req_in.burst |=> $stable(ctrl_q);
  endproperty
  a_burst: assert property (p_burst)
    else $error("control changed inside a burst");

  property p_stat;
    @(posedge mclk_in) disable iff (rst_in)
    s_stat_rd |=> rd_data_out[0] == $past(sleeping_in)
                  && rd_data_out[1] == $past(proto_q)
                  && rd_data_out[3:2] == 2'b00
                  && rd_data_out[7:4] == $past(not_ready_in);
  endproperty
  a_stat: assert property (p_stat)
    else $error("status byte wrong");

  property p_chan_zero;
    @(posedge mclk_in) disable iff (rst_in)
    req_in.rd && in_chan && not_ready_in[addr[1:0]] |=> rd_data_out == 8'h00;
  endproperty
  a_chan_zero: assert property (p_chan_zero)
    else $error("not-ready channel returned data");

  property p_ro;
    @(posedge mclk_in) disable iff (rst_in)
    req_in.wr && (addr == host_regs_pkg::STAT_ADDR) |=> $stable(ctrl_q);
  endproperty
  a_ro: assert property (p_ro)
    else $error("status write changed state");

endmodule

`default_nettype wire

// File: design/i2c_watchdog.sv
// Purpose: two-wire bus inactivity watchdog, 1 ms or 50 ms
// Assumes: run_in already folds in enable, mode, oscillator, sleep
// Notes:   millisecond tick comes from a divider on the system clock

`timescale 1ns/10ps
`default_nettype none

module i2c_watchdog #(
  parameter int unsigned MS_CYCLES = host_regs_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // control
  input  wire logic run_in,
  input  wire logic long_in,
  input  wire logic activity_in,
  // event
  output logic      timeout_out
);

  logic [15:0] div_q;
  logic [5:0]  ms_q;
  logic        ms_tick;
  logic [5:0]  limit;

  // millisecond enable pulse and selected limit
  assign ms_tick = (div_q == 16'(MS_CYCLES - 1));
  assign limit   = long_in ? host_regs_pkg::WD_LONG_MS
                           : host_regs_pkg::WD_SHORT_MS;

  // bus traffic or a stopped oscillator restarts the whole count
  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in || activity_in) begin
      div_q       <= 16'h0000;
      ms_q        <= 6'h00;
      timeout_out <= 1'b0;
    end else begin
      timeout_out <= 1'b0;
      if (ms_tick) begin
        div_q <= 16'h0000;
        if (ms_q + 6'h01 == limit) begin
          ms_q        <= 6'h00;
          timeout_out <= 1'b1;
        end else begin
          ms_q <= ms_q + 6'h01;
        end
      end else begin
        div_q <= div_q + 16'h0001;
      end
    end
  end

  property p_wd_halt;
    @(posedge mclk_in) disable iff (rst_in)
    !run_in |=> !timeout_out;
  endproperty
  a_wd_halt: assert property (p_wd_halt)
    else $error("watchdog fired while halted");

  property p_wd_tick;
    @(posedge mclk_in) disable iff (rst_in)
    timeout_out |-> $past(ms_tick) && $past(run_in);
  endproperty
  a_wd_tick: assert property (p_wd_tick)
    else $error("watchdog fired off a millisecond tick");

endmodule

`default_nettype wire

// File: shared/host_regs_pkg.sv
// Purpose: shared constants and types for the host link register slice
// Assumes: 25 MHz system clock, byte wide host register transactions
// Notes:   offsets, field positions, reset values and counts live here

package host_regs_pkg;

  // register byte addresses
  localparam logic [7:0] CHAN_LAST_ADDR = 8'h03;
  localparam logic [7:0] TS_TRIG_ADDR   = 8'h15;
  localparam logic [7:0] CTRL_ADDR      = 8'h16;
  localparam logic [7:0] STAT_ADDR      = 8'h17;
  localparam logic [7:0] HITS_FIRST     = 8'h26;
  localparam logic [7:0] HITS_LAST      = 8'h2a;

  // field positions
  localparam int TS_TRIG_BIT = 0;
  localparam int CTRL_3W_BIT = 0;
  localparam int CTRL_WD_BIT = 1;
  localparam int CTRL_TO_BIT = 2;

  // values after reset, writable field mask
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [7:0]  CTRL_MASK = 8'h07;
  localparam logic [39:0] TS_RST    = 40'h00_0000_0000;

  // timestamp event packet layout
  localparam logic [15:0] PKT_CODE = 16'h0000;
  localparam logic [15:0] PKT_LEN  = 16'h0008;
  localparam logic [3:0]  PKT_LAST = 4'hb;

  // watchdog timing
  localparam int          CLK_HZ      = 25_000_000;
  localparam int          MS_PER_S    = 1000;
  localparam int          MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam logic [5:0]  WD_SHORT_MS = 6'h01;
  localparam logic [5:0]  WD_LONG_MS  = 6'h32;

  // one host register transaction, valid for one cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       burst;
    logic [7:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  typedef enum logic {
    PKT_IDLE = 1'b0,
    PKT_SEND = 1'b1
  } pkt_state_t;

endpackage

// File: sim/host_model.sv
// Purpose: host side model, byte register requests and packet sink
// Assumes: requests launched 1 ns after the rising clock edge
// Notes:   the sink stalls one cycle in three to test back pressure

`timescale 1ns/10ps
`default_nettype none

module host_model (
  // clock
  input  wire logic                mclk_in,
  // register requests
  output var host_regs_pkg::host_req_t req_out,
  input  wire logic [7:0]          rd_data_in,
  // packet sink
  input  wire logic                pkt_valid_in,
  input  wire logic [7:0]          pkt_byte_in,
  input  wire logic                pkt_last_in,
  output logic                     pkt_ready_out
);
  logic [8:0] got [$];
  logic [1:0] stall_q;

  initial begin
    req_out = '0;
    pkt_ready_out = 1'b0;
    stall_q = 2'h0;
  end

  // one request per call; an idle cycle between calls avoids re-driving
  // the strobe in the same time step; burst only when a scenario asks
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      input logic b, output logic [7:0] q);
    @(posedge mclk_in);
    #1 req_out = '{wr: w, rd: !w, burst: b, addr: a, wdata: d};
    @(posedge mclk_in);
    #1 req_out = '0;
    q = rd_data_in;
  endtask

  // collect bytes with their end flag; ready moves just after the edge
  always @(posedge mclk_in) begin
    if (pkt_valid_in && pkt_ready_out)
      got.push_back({pkt_last_in, pkt_byte_in});
    #1 stall_q = (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    pkt_ready_out = (stall_q != 2'h0);
  end
endmodule

`default_nettype wire

// File: sim/tb_top.sv
// Purpose: self-checking bench for the host link register slice
// Assumes: watchdog millisecond shortened to 10 clock cycles
// Notes:   watchdog figures get a few cycles of slack for pipeline delay

`timescale 1ns/10ps
`default_nettype none

module tb_top;
  localparam int MS = 10;
  logic                     mclk, rst, sleeping, deep, osc_en, pin;
  logic                     to_reg, pkt_valid, pkt_last, pkt_ready;
  logic                     activity, spi3, wd_to;
  logic [7:0]               rd_data, chan_data, pkt_byte;
  logic [3:0]               not_ready;
  logic [39:0]              timer, ts_reg;
  host_regs_pkg::host_req_t req;
  int                       fails, comparisons;

  host_link_regs #(.MS_CYCLES(MS)) dut_u (
    .mclk_in(mclk), .rst_in(rst), .req_in(req), .rd_data_out(rd_data),
    .chan_data_in(chan_data), .not_ready_in(not_ready),
    .sleeping_in(sleeping), .deep_sleep_in(deep), .timer_osc_en_in(osc_en),
    .proto_pin_in(pin), .ts_to_reg_in(to_reg), .timer_in(timer),
    .ts_reg_out(ts_reg), .pkt_valid_out(pkt_valid), .pkt_byte_out(pkt_byte),
    .pkt_last_out(pkt_last), .pkt_ready_in(pkt_ready),
    .i2c_activity_in(activity), .spi_3wire_out(spi3),
    .wd_timeout_out(wd_to));

  host_model host_u (
    .mclk_in(mclk), .req_out(req), .rd_data_in(rd_data),
    .pkt_valid_in(pkt_valid), .pkt_byte_in(pkt_byte),
    .pkt_last_in(pkt_last), .pkt_ready_out(pkt_ready));

  // clock generator
  always #20 mclk = ~mclk;

  task automatic check(input logic [63:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (fails == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d, input logic b);
    logic [7:0] q;
    host_u.xfer(1'b1, a, d, b, q);
  endtask

  task automatic rd(input logic [7:0] a, x);
    logic [7:0] q;
    host_u.xfer(1'b0, a, 8'h00, 1'b0, q);
    check(64'(q), 64'(x));
  endtask

  // the strap is captured once, so a protocol change needs a reset
  task automatic do_reset(input logic p);
    pin = p;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // count cycles until a watchdog pulse, giving up at lim
  task automatic wait_to(input int lim, output int n);
    n = 0;
    while (wd_to !== 1'b1 && n < lim) begin
      @(posedge mclk);
      #1 n++;
    end
  endtask

  task automatic t_regs;
    int n;
    rd(host_regs_pkg::STAT_ADDR, 8'ha3);
    rd(host_regs_pkg::CTRL_ADDR, host_regs_pkg::CTRL_RST);
    wr(host_regs_pkg::CTRL_ADDR, 8'hff, 1'b0);
    rd(host_regs_pkg::CTRL_ADDR, 8'h07);
    check(64'(spi3), 64'h1);
    wr(host_regs_pkg::CTRL_ADDR, 8'h00, 1'b1);
    rd(host_regs_pkg::CTRL_ADDR, 8'h07);
    wr(host_regs_pkg::STAT_ADDR, 8'h0c, 1'b0);
    rd(host_regs_pkg::STAT_ADDR, 8'ha3);
    sleeping = 1'b0;
    not_ready = 4'h5;
    rd(host_regs_pkg::STAT_ADDR, 8'h52);
    rd(host_regs_pkg::TS_TRIG_ADDR, 8'h00);
    // short limit armed, but serial peripheral mode keeps the watchdog still
    wr(host_regs_pkg::CTRL_ADDR, 8'h02, 1'b0);
    wait_to(2 * MS, n);
    check(64'(n), 64'(2 * MS));
    check(64'(spi3), 64'h0);
  endtask

  task automatic t_chan;
    chan_data = 8'h5a;
    not_ready = 4'h9;
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h5a);
    rd(host_regs_pkg::CHAN_LAST_ADDR, 8'h00);
    not_ready = 4'h0;
    rd(8'h00, 8'h5a);
  endtask

  task automatic t_ts_reg;
    to_reg = 1'b1;
    timer = 40'h12_3456_789a;
    wr(host_regs_pkg::TS_TRIG_ADDR, 8'hfe, 1'b0);
    @(posedge mclk);
    #1 check(64'(ts_reg), 64'(host_regs_pkg::TS_RST));
    wr(host_regs_pkg::TS_TRIG_ADDR, 8'h01, 1'b0);
    timer = 40'h0;
    @(posedge mclk);
    #1 check(64'(ts_reg), 64'h12_3456_789a);
    for (int i = 0; i < 5; i++)
      rd(host_regs_pkg::HITS_FIRST + 8'(i),
         8'(40'h12_3456_789a >> (8 * i)));
    check(64'(host_u.got.size()), 64'h0);
  endtask

  task automatic t_pkt;
    logic [95:0] e;
    int          n;
    to_reg = 1'b0;
    timer = 40'hab_cdef_0123;
    e = {24'h0, timer, host_regs_pkg::PKT_LEN, host_regs_pkg::PKT_CODE};
    wr(host_regs_pkg::TS_TRIG_ADDR, 8'h01, 1'b0);
    n = 0;
    while (host_u.got.size() < 12 && n < 100) begin
      @(posedge mclk);
      #1 n++;
    end
    repeat (4) @(posedge mclk);
    #1 check(64'(host_u.got.size()), 64'd12);
    for (int i = 0; i < 12 && i < host_u.got.size(); i++)
      check(64'(host_u.got[i]), 64'({i == 11, e[8*i+:8]}));
    check(64'(ts_reg), 64'h12_3456_789a);
  endtask

  task automatic t_wd;
    int n;
    do_reset(1'b0);
    rd(host_regs_pkg::STAT_ADDR, 8'h00);
    wr(host_regs_pkg::CTRL_ADDR, 8'h03, 1'b0);
    wait_to(MS + 20, n);
    check(64'(n >= MS - 3 && n <= MS + 3), 64'h1);
    check(64'(spi3), 64'h0);
    // steady bus traffic must hold the watchdog off
    activity = 1'b1;
    @(posedge mclk);
    #1;
    wait_to(2 * MS, n);
    check(64'(n), 64'(2 * MS));
    activity = 1'b0;
    wr(host_regs_pkg::CTRL_ADDR, 8'h06, 1'b0);
    wait_to(50 * MS + 20, n);
    check(64'(n >= 50 * MS - 3 && n <= 50 * MS + 3), 64'h1);
    deep = 1'b1;
    wr(host_regs_pkg::CTRL_ADDR, 8'h02, 1'b0);
    wait_to(4 * MS, n);
    check(64'(n), 64'(4 * MS));
    deep = 1'b0;
    osc_en = 1'b0;
    wait_to(4 * MS, n);
    check(64'(n), 64'(4 * MS));
    wr(host_regs_pkg::CTRL_ADDR, 8'h00, 1'b0);
    osc_en = 1'b1;
    wait_to(4 * MS, n);
    check(64'(n), 64'(4 * MS));
  endtask

  // watchdog on the whole run, far beyond the expected 770 cycles or so
  initial begin
    #200_000;
    fails++;
    final_report();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    fails = 0;
    comparisons = 0;
    sleeping = 1'b1;
    deep = 1'b0;
    osc_en = 1'b1;
    to_reg = 1'b0;
    activity = 1'b0;
    chan_data = 8'h00;
    not_ready = 4'ha;
    timer = 40'h0;
    do_reset(1'b1);
    t_regs();
    t_chan();
    t_ts_reg();
    t_pkt();
    t_wd();
    final_report();
  end
endmodule

`default_nettype wire
